// file: common/fsp_defs.vh
// Constants for the flash status and protection register block
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define FSP_OP_WRSR 8'h01
`define FSP_OP_PROG 8'h02
`define FSP_OP_RDSR1 8'h05
`define FSP_OP_WREN 8'h06
`define FSP_OP_ERASE4K 8'h20
`define FSP_OP_RDSR2 8'h35
`define FSP_OP_VWREN 8'h50
`define FSP_OP_ERASE32K 8'h52
`define FSP_OP_RDSRI 8'h65
`define FSP_OP_WRSRI 8'h71
`define FSP_OP_SUSPEND 8'h75
`define FSP_OP_RESUME 8'h7a
`define FSP_OP_CHIPERASE 8'hc7
`define FSP_OP_ERASE64K 8'hd8

// ****************************************************************
// Indirect register addresses
// ****************************************************************
`define FSP_REG_ONE 8'h01
`define FSP_REG_TWO 8'h02

// ****************************************************************
// Status bit positions and reset values
// ****************************************************************
`define FSP_BIT_BUSY 0
`define FSP_BIT_WEL 1
`define FSP_RANGE_LSB 2
`define FSP_RANGE_MSB 4
`define FSP_BIT_DIR 5
`define FSP_BIT_GRAN 6
`define FSP_BIT_SUSPENDED_FLAG 7
`define FSP_RANGE_RST 3'h0
`define FSP_DIR_RST 1'b0
`define FSP_GRAN_RST 1'b0

// ****************************************************************
// Array geometry
// ****************************************************************
`define FSP_ADDR_W 22
`define FSP_ARRAY_BYTES 23'h400000
`define FSP_GRAN_SMALL 23'h001000
`define FSP_GRAN_LARGE 23'h010000
`define FSP_MASK_PAGE 22'h0000ff
`define FSP_MASK_4K 22'h000fff
`define FSP_MASK_32K 22'h007fff
`define FSP_MASK_64K 22'h00ffff
`define FSP_MASK_ALL 22'h3fffff

// ****************************************************************
// Timing
// ****************************************************************
`define FSP_CLK_NS 50
`define FSP_T_PROG_NS 100000
`define FSP_T_ERASE_NS 1000000
`define FSP_T_SRW_NS 50000
`define FSP_PROG_CYC ((`FSP_T_PROG_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_ERASE_CYC ((`FSP_T_ERASE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SRW_CYC ((`FSP_T_SRW_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_LEN_W 20

// Pin states at reset: hw reset high, mosi low, cs high, sck low
`define FSP_SYNC_RST 4'ha
// Reset pattern seen on data at four chip-select pulses
`define FSP_JEDEC_PAT 4'h5

`endif

// file: hw/fsp_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module fsp_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire clk_sys_i,
   input wire srst_i,
   input wire [WIDTH-1:0] d_i,
   output reg [WIDTH-1:0] q_o
);

   reg [WIDTH-1:0] meta;

   // First stage feeds only the second
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule

// file: hw/fsp_busy_timer.v
// Internal operation timer with suspend and resume
`timescale 1ns/1ps

module fsp_busy_timer #(
   parameter LEN_W = 20
) (
   input wire clk_sys_i,
   input wire srst_i,
   input wire start_i,
   input wire [LEN_W-1:0] len_i,
   input wire pause_i,
   input wire resume_i,
   output wire busy_o,
   output reg done_o
);

   reg [LEN_W-1:0] cnt;
   reg run;
   reg hold;

   // Busy only while counting, not while held
   assign busy_o = run & ~hold;

   // Count down, freeze while held
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         cnt <= {LEN_W{1'b0}};
         run <= 1'b0;
         hold <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt <= len_i;
            run <= 1'b1;
            hold <= 1'b0;
         end else if (run) begin
            if (pause_i) begin
               hold <= 1'b1;
            end else if (resume_i) begin
               hold <= 1'b0;
            end else if (!hold) begin
               if (cnt <= {{(LEN_W-1){1'b0}}, 1'b1}) begin
                  run <= 1'b0;
                  done_o <= 1'b1;
               end else begin
                  cnt <= cnt - {{(LEN_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

endmodule

// file: hw/fsp_status_regs.v
// Flash status and block protection registers behind an SPI slave
`timescale 1ns/1ps
`include "fsp_defs.vh"

// Functional notes
// R1: Granule bit picks 64 kB blocks at 0, 4 kB blocks at 1.
// R2: Direction bit 5: 0 protects from bottom up, 1 from top down.
// R3: Three-bit range in bits 4:2; protected part refuses program and erase.
// R4: Range resets to zero, nothing protected.
// R5: Range is loaded by the status-one write command 01h.
// R6: With latch at 0, program, erase and status writes not preceded by 50h are ignored.
// R7: Write-enable latch is 0 after power-up and any reset.
// R8: Incomplete or unknown command at deselect leaves the latch set.
// R9: A fully shifted but aborted write command clears the latch.
// R10: Opcode 06h sets the latch; 50h leaves it alone.
// R11: Bit 0 of status one reads 1 while busy, else 0.
// R12: Host polls fresh status bytes until busy drops.
// R13: Suspend 75h sets the suspended flag, bit 7 of status two.
// R14: Resume 7Ah and both hardware resets clear the suspended flag.
// R15: Status one via 05h/01h, or 65h/71h with register address 01h.
// R16: A status write after 50h is volatile, after 06h non-volatile.
// R17: Completion of a write operation clears the latch and busy.
module fsp_status_regs #(
   parameter [`FSP_LEN_W-1:0] PROG_CYC = `FSP_PROG_CYC,
   parameter [`FSP_LEN_W-1:0] ERASE_CYC = `FSP_ERASE_CYC,
   parameter [`FSP_LEN_W-1:0] SRW_CYC = `FSP_SRW_CYC
) (
   input wire clk_sys_i,
   input wire srst_i,
   input wire spi_sck_i,
   input wire spi_cs_n_i,
   input wire spi_mosi_i,
   input wire hw_reset_n_i,
   output reg spi_miso_o,
   output reg spi_miso_oe_o,
   output reg write_enable_latch_o,
   output reg suspended_flag_o
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Address inside the protected region
   function prot_hit;
      input [`FSP_ADDR_W-1:0] a;
      input g;
      input d;
      input [2:0] r;
      reg [22:0] sz;
      begin
         sz = (g ? `FSP_GRAN_SMALL : `FSP_GRAN_LARGE) << (r - 3'd1);
         if (r == 3'd0)
            prot_hit = 1'b0; // see R4
         else if (r == 3'd7)
            prot_hit = 1'b1;
         else if (d)
            prot_hit = ({1'b0, a} >= (`FSP_ARRAY_BYTES - sz)); // see R2
         else
            prot_hit = ({1'b0, a} < sz); // see R2
      end
   endfunction
   // Span of bytes an array command touches
   function [`FSP_ADDR_W-1:0] op_mask;
      input [7:0] op;
      begin
         case (op)
            `FSP_OP_ERASE4K: op_mask = `FSP_MASK_4K;
            `FSP_OP_ERASE32K: op_mask = `FSP_MASK_32K;
            `FSP_OP_ERASE64K: op_mask = `FSP_MASK_64K;
            `FSP_OP_CHIPERASE: op_mask = `FSP_MASK_ALL;
            default: op_mask = `FSP_MASK_PAGE;
         endcase
      end
   endfunction

   // ****************************************************************
   // Pin synchronisation and edges
   // ****************************************************************
   wire [3:0] pins_s;
   wire s_sck = pins_s[0];
   wire s_cs_n = pins_s[1];
   wire s_mosi = pins_s[2];
   wire s_hwrst_n = pins_s[3];
   reg sck_d;
   reg cs_n_d;

   fsp_sync #(
      .WIDTH(4),
      .RST_VAL(`FSP_SYNC_RST)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .d_i({hw_reset_n_i, spi_mosi_i, spi_cs_n_i, spi_sck_i}),
      .q_o(pins_s)
   );
   // Delayed copies for edge finding
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         sck_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sck_d <= s_sck;
         cs_n_d <= s_cs_n;
      end
   end

   wire sck_rise = s_sck & ~sck_d & ~s_cs_n;
   wire sck_fall = ~s_sck & sck_d & ~s_cs_n;
   wire cs_rise = s_cs_n & ~cs_n_d;
   wire cs_fall = ~s_cs_n & cs_n_d;

   // ****************************************************************
   // State
   // ****************************************************************
   reg [2:0] bit_cnt;
   reg [2:0] byte_cnt;
   reg [7:0] rx_sh;
   reg [7:0] cmd;
   reg [7:0] b1;
   reg [7:0] b2;
   reg [7:0] b3;
   reg [7:0] tx_sh;
   reg vol_we;
   reg gran;
   reg dir;
   reg [2:0] range;
   reg arr_op;
   reg t_start;
   reg t_pause;
   reg t_resume;
   reg [`FSP_LEN_W-1:0] t_len;
   reg [3:0] jd_pat;
   reg jd_bit;
   reg sck_seen;
   reg jedec_p;
   wire t_busy;
   wire t_done;
   wire dev_rst = ~s_hwrst_n | jedec_p;

   fsp_busy_timer #(
      .LEN_W(`FSP_LEN_W)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i | dev_rst),
      .start_i(t_start),
      .len_i(t_len),
      .pause_i(t_pause),
      .resume_i(t_resume),
      .busy_o(t_busy),
      .done_o(t_done)
   );
   // Status bytes; busy held through done so it drops with the latch
   wire [7:0] sr_one = {1'b0, gran, dir, range,
      write_enable_latch_o, t_busy | t_done}; // see R11, R17
   wire [7:0] sr_two = {suspended_flag_o, 7'h00}; // see R13
   // ****************************************************************
   // Command decode
   // ****************************************************************
   wire [`FSP_ADDR_W-1:0] addr = {b1[5:0], b2, b3};
   wire [`FSP_ADDR_W-1:0] mask = op_mask(cmd);
   wire hit = prot_hit(addr & ~mask, gran, dir, range) |
      prot_hit(addr | mask, gran, dir, range); // see R1, R3
   wire sr_wr = ((cmd == `FSP_OP_WRSR) && (byte_cnt == 3'd2)) ||
      ((cmd == `FSP_OP_WRSRI) && (byte_cnt == 3'd3) &&
      (b1 == `FSP_REG_ONE)); // see R5, R15
   wire [7:0] sr_val = (cmd == `FSP_OP_WRSR) ? b1 : b2;
   wire is_erase = (cmd == `FSP_OP_ERASE4K) ||
      (cmd == `FSP_OP_ERASE32K) || (cmd == `FSP_OP_ERASE64K);
   wire arr_full = ((cmd == `FSP_OP_PROG) && (byte_cnt >= 3'd5)) ||
      (is_erase && (byte_cnt == 3'd4)) ||
      ((cmd == `FSP_OP_CHIPERASE) && (byte_cnt == 3'd1));
   wire one_byte = (byte_cnt == 3'd1);
   wire rd_on = (((cmd == `FSP_OP_RDSR1) || (cmd == `FSP_OP_RDSR2)) &&
      (byte_cnt != 3'd0)) ||
      ((cmd == `FSP_OP_RDSRI) && (byte_cnt >= 3'd2));
   wire [7:0] rd_byte = (cmd == `FSP_OP_RDSR1) ? sr_one :
      (cmd == `FSP_OP_RDSR2) ? sr_two :
      (b1 == `FSP_REG_ONE) ? sr_one :
      (b1 == `FSP_REG_TWO) ? sr_two : 8'h00; // see R15

   // ****************************************************************
   // Receive shifter
   // ****************************************************************
   // Shift on rising clock edge, bytes counted up to seven
   always @(posedge clk_sys_i) begin
      if (srst_i || dev_rst || s_cs_n) begin
         bit_cnt <= 3'd0;
         byte_cnt <= 3'd0;
         rx_sh <= 8'h00;
      end else if (sck_rise) begin
         rx_sh <= {rx_sh[6:0], s_mosi};
         bit_cnt <= bit_cnt + 3'd1;
         if ((bit_cnt == 3'd7) && (byte_cnt != 3'd7))
            byte_cnt <= byte_cnt + 3'd1;
      end
   end

   // Capture command and the bytes after it
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         cmd <= 8'h00;
         b1 <= 8'h00;
         b2 <= 8'h00;
         b3 <= 8'h00;
      end else if (sck_rise && (bit_cnt == 3'd7)) begin
         case (byte_cnt)
            3'd0: cmd <= {rx_sh[6:0], s_mosi};
            3'd1: b1 <= {rx_sh[6:0], s_mosi};
            3'd2: b2 <= {rx_sh[6:0], s_mosi};
            3'd3: b3 <= {rx_sh[6:0], s_mosi};
            default: b3 <= b3;
         endcase
      end
   end

   // ****************************************************************
   // Transmit shifter
   // ****************************************************************
   // Fresh status loaded at each byte boundary
   always @(posedge clk_sys_i) begin
      if (srst_i || dev_rst || s_cs_n) begin
         tx_sh <= 8'h00;
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else if (sck_fall && rd_on) begin
         spi_miso_oe_o <= 1'b1;
         if (bit_cnt == 3'd0) begin
            spi_miso_o <= rd_byte[7]; // see R12
            tx_sh <= {rd_byte[6:0], 1'b0};
         end else begin
            spi_miso_o <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // Pin reset sequence detector
   // ****************************************************************
   // Data level at each select pulse with no clock activity
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         jd_pat <= 4'h0;
         jd_bit <= 1'b0;
         sck_seen <= 1'b0;
         jedec_p <= 1'b0;
      end else begin
         jedec_p <= 1'b0;
         if (cs_fall) begin
            jd_bit <= s_mosi;
            sck_seen <= 1'b0;
         end else if ((s_sck ^ sck_d) && !s_cs_n) begin
            sck_seen <= 1'b1;
         end
         if (cs_rise) begin
            if (sck_seen) begin
               jd_pat <= 4'h0;
            end else if ({jd_pat[2:0], jd_bit} == `FSP_JEDEC_PAT) begin
               jd_pat <= 4'h0;
               jedec_p <= 1'b1; // see R14
            end else begin
               jd_pat <= {jd_pat[2:0], jd_bit};
            end
         end
      end
   end

   // ****************************************************************
   // Command execution at deselect
   // ****************************************************************
   // Commands act only on whole bytes at chip-select release
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         write_enable_latch_o <= 1'b0; // see R7
         suspended_flag_o <= 1'b0;
         vol_we <= 1'b0;
         gran <= `FSP_GRAN_RST;
         dir <= `FSP_DIR_RST;
         range <= `FSP_RANGE_RST; // see R4
         arr_op <= 1'b0;
         t_start <= 1'b0;
         t_pause <= 1'b0;
         t_resume <= 1'b0;
         t_len <= {`FSP_LEN_W{1'b0}};
      end else begin
         t_start <= 1'b0;
         t_pause <= 1'b0;
         t_resume <= 1'b0;
         if (dev_rst) begin
            write_enable_latch_o <= 1'b0; // see R7
            suspended_flag_o <= 1'b0; // see R14
            vol_we <= 1'b0;
            arr_op <= 1'b0;
         end else begin
            if (t_done)
               write_enable_latch_o <= 1'b0; // see R17
            if (cs_rise && (bit_cnt == 3'd0)) begin
               if ((cmd == `FSP_OP_WREN) && one_byte && !t_busy) begin
                  write_enable_latch_o <= 1'b1; // see R10
               end else if ((cmd == `FSP_OP_VWREN) && one_byte &&
                  !t_busy) begin
                  vol_we <= 1'b1; // see R10
               end else if (sr_wr && !t_busy && !suspended_flag_o) begin
                  if (vol_we || write_enable_latch_o) begin
                     gran <= sr_val[`FSP_BIT_GRAN]; // see R1
                     dir <= sr_val[`FSP_BIT_DIR]; // see R2
                     range <= sr_val[`FSP_RANGE_MSB:`FSP_RANGE_LSB]; // see R5
                  end
                  if (vol_we) begin
                     vol_we <= 1'b0; // see R16
                  end else if (write_enable_latch_o) begin
                     t_start <= 1'b1; // see R16
                     t_len <= SRW_CYC;
                     arr_op <= 1'b0;
                  end
               end else if (arr_full && !t_busy && !suspended_flag_o &&
                  write_enable_latch_o) begin // see R6
                  if (hit) begin
                     write_enable_latch_o <= 1'b0; // see R3, R9
                  end else begin
                     t_start <= 1'b1;
                     t_len <= (cmd == `FSP_OP_PROG) ? PROG_CYC : ERASE_CYC;
                     arr_op <= 1'b1;
                  end
               end else if ((cmd == `FSP_OP_SUSPEND) && one_byte &&
                  t_busy && arr_op) begin
                  t_pause <= 1'b1;
                  suspended_flag_o <= 1'b1; // see R13
               end else if ((cmd == `FSP_OP_RESUME) && one_byte &&
                  suspended_flag_o) begin
                  t_resume <= 1'b1;
                  suspended_flag_o <= 1'b0; // see R14
               end
            end // Partial or other commands keep the latch, see R8
         end
      end
   end

endmodule

// file: dv/fsp_status_regs_props.sv
// Pin-level assertions for the flash status register block
`timescale 1ns/1ps

module fsp_status_regs_props (
   input wire clk_sys_i,
   input wire srst_i,
   input wire spi_sck_i,
   input wire spi_cs_n_i,
   input wire spi_mosi_i,
   input wire hw_reset_n_i,
   input wire spi_miso_o,
   input wire spi_miso_oe_o,
   input wire write_enable_latch_o,
   input wire suspended_flag_o
);
   // ************************************************************
   // Clocking and assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   AST_HWR_WEL: assert property (!hw_reset_n_i [*4] |->
      !write_enable_latch_o) else $error("latch kept in reset");
   AST_HWR_SUSPENDED_FLAG: assert property (!hw_reset_n_i [*4] |->
      !suspended_flag_o) else $error("suspend kept in reset");
   AST_OE_IDLE: assert property (spi_cs_n_i [*5] |->
      !spi_miso_oe_o) else $error("miso driven while deselected");
   AST_OE_START: assert property ($rose(spi_miso_oe_o) |->
      !$past(spi_cs_n_i, 4)) else $error("miso enabled without select");
   AST_MISO_EDGE: assert property (spi_miso_oe_o &&
      !$stable(spi_miso_o) |-> !$past(spi_sck_i, 3))
      else $error("miso moved off a falling clock");
   AST_WEL_SET: assert property ($rose(write_enable_latch_o) |->
      $past(spi_cs_n_i, 3)) else $error("latch set inside a frame");
   AST_SUSPENDED_FLAG_SET: assert property ($rose(suspended_flag_o) |->
      $past(spi_cs_n_i, 3)) else $error("suspend set inside a frame");
   AST_SUSPENDED_FLAG_CLR: assert property ($fell(suspended_flag_o) |->
      $past(spi_cs_n_i, 3) || $past(spi_cs_n_i, 6) ||
      !$past(hw_reset_n_i, 3)) else $error("suspend cleared with no cause");

   // Main scenarios reached
   C_WEL: cover property ($rose(write_enable_latch_o));
   C_SUSPENDED_FLAG: cover property ($rose(suspended_flag_o));
   C_READ: cover property ($rose(spi_miso_oe_o));
endmodule

bind fsp_status_regs fsp_status_regs_props u_props (
   .clk_sys_i(clk_sys_i),
   .srst_i(srst_i),
   .spi_sck_i(spi_sck_i),
   .spi_cs_n_i(spi_cs_n_i),
   .spi_mosi_i(spi_mosi_i),
   .hw_reset_n_i(hw_reset_n_i),
   .spi_miso_o(spi_miso_o),
   .spi_miso_oe_o(spi_miso_oe_o),
   .write_enable_latch_o(write_enable_latch_o),
   .suspended_flag_o(suspended_flag_o)
);

// file: dv/fsp_spi_host.sv
// SPI host model issuing flash commands in mode 0
`timescale 1ns/1ps

module fsp_spi_host (
   input wire clk_sys_i,
   input wire spi_miso_i,
   output reg spi_sck_o,
   output reg spi_cs_n_o,
   output reg spi_mosi_o
);
   // Idle pins: clock parked low, device deselected
   initial begin
      spi_sck_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // One bit: data set while clock low, miso taken before the fall
   task bit_xfer(input logic b, output logic r);
      begin
         spi_mosi_o <= b;
         repeat (4) @(posedge clk_sys_i);
         spi_sck_o <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         r = spi_miso_i;
         spi_sck_o <= 1'b0;
      end
   endtask

   // Frame: nbits out MSB first, then up to nrd bytes read back
   task frame(input int nbits, input logic [63:0] tx, input int nrd,
      input logic stop, output logic [7:0] first, output logic [7:0] rd);
      logic r;
      begin
         spi_cs_n_o <= 1'b0;
         for (int i = nbits - 1; i >= 0; i--) bit_xfer(tx[i], r);
         for (int n = 0; n < nrd; n++) begin
            for (int k = 0; k < 8; k++) begin
               bit_xfer(1'b0, r);
               rd = {rd[6:0], r};
            end
            if (n == 0) first = rd;
            if (stop && !rd[0]) break;
         end
         repeat (4) @(posedge clk_sys_i);
         spi_cs_n_o <= 1'b1;
         spi_mosi_o <= ~spi_mosi_o;
         repeat (8) @(posedge clk_sys_i);
      end
   endtask

   // Four select pulses, no clock, data 0 1 0 1 at each fall
   task pin_reset;
      begin
         for (int i = 0; i < 4; i++) begin
            spi_mosi_o <= i[0];
            @(posedge clk_sys_i);
            spi_cs_n_o <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            spi_cs_n_o <= 1'b1;
            repeat (5) @(posedge clk_sys_i);
         end
      end
   endtask
endmodule

// file: dv/fsp_status_regs_tb.sv
// Self-checking bench for the flash status register block
`timescale 1ns/1ps

module fsp_status_regs_tb;
   reg clk_sys;
   reg srst;
   reg hw_reset_n;
   wire sck;
   wire cs_n;
   wire mosi;
   wire miso;
   wire miso_oe;
   wire write_enable_latch;
   wire suspended_flag;
   // Released data line reads high, since miso is held low whenever its enable is low
   wire miso_line = miso_oe ? miso : ~miso;
   logic [7:0] rd_first;
   logic [7:0] rd_last;
   logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hd8};
   int n_fail = 0;
   int checks_done = 0;

   // ************************************************************
   // Clock, design and host model
   // ************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   fsp_status_regs #(.PROG_CYC(20'd300), .ERASE_CYC(20'd600),
      .SRW_CYC(20'd200)) uut (
      .clk_sys_i(clk_sys),
      .srst_i(srst),
      .spi_sck_i(sck),
      .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi),
      .hw_reset_n_i(hw_reset_n),
      .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe),
      .write_enable_latch_o(write_enable_latch),
      .suspended_flag_o(suspended_flag)
   );

   fsp_spi_host host (
      .clk_sys_i(clk_sys),
      .spi_miso_i(miso_line),
      .spi_sck_o(sck),
      .spi_cs_n_o(cs_n),
      .spi_mosi_o(mosi)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      begin
         checks_done++;
         if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
         end
      end
   endtask

   task wr(input int nb, input logic [63:0] tx);
      host.frame(nb, tx, 0, 1'b0, rd_first, rd_last);
   endtask

   task rdreg(input int nb, input logic [15:0] hdr, input logic [7:0] exp);
      begin
         host.frame(nb, {48'h0, hdr}, 1, 1'b0, rd_first, rd_last);
         check("status byte", rd_last, exp);
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d, mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      srst <= 1'b1;
      hw_reset_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rdreg(8, 16'h05, 8'h00);
      rdreg(8, 16'h35, 8'h00);
      rdreg(16, 16'h6501, 8'h00);
      wr(16, 64'h017c);
      rdreg(8, 16'h05, 8'h00);
      wr(8, 64'h06);
      rdreg(8, 16'h05, 8'h02);
      wr(4, 64'h0);
      wr(8, 64'hff);
      rdreg(8, 16'h05, 8'h02);
      // Stored write: busy while it runs, then latch drops
      wr(16, 64'h017c);
      host.frame(8, 64'h05, 64, 1'b1, rd_first, rd_last);
      check("first poll byte", rd_first, 8'h7f);
      check("last poll byte", rd_last, 8'h7c);
      // Volatile write by register address, no busy, latch kept
      wr(8, 64'h50);
      wr(24, 64'h710124);
      rdreg(16, 16'h6501, 8'h24);
      // Top granule protected: refused program clears the latch
      wr(8, 64'h06);
      wr(40, 64'h023ffff0aa);
      rdreg(8, 16'h05, 8'h24);
      wr(8, 64'h06);
      wr(40, 64'h02000000aa);
      rdreg(8, 16'h05, 8'h27);
      wr(8, 64'h75);
      rdreg(8, 16'h35, 8'h80);
      rdreg(16, 16'h6502, 8'h80);
      check("suspend pin", {7'h0, suspended_flag}, 8'h01);
      wr(8, 64'h7a);
      rdreg(8, 16'h35, 8'h00);
      host.frame(8, 64'h05, 64, 1'b1, rd_first, rd_last);
      check("program done", rd_last, 8'h24);
      // Refused chip erase over the protected top granule
      wr(8, 64'h06);
      wr(8, 64'hc7);
      rdreg(8, 16'h05, 8'h24);
      // Erases with latch clear are ignored
      foreach (ops[i]) begin
         wr(32, {32'h0, ops[i], 24'h0});
         rdreg(8, 16'h05, 8'h24);
      end
      // Hardware reset pin during a suspended erase
      wr(8, 64'h06);
      wr(32, 64'hd8000000);
      wr(8, 64'h75);
      hw_reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      hw_reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("suspend pin", {7'h0, suspended_flag}, 8'h00);
      check("latch pin", {7'h0, write_enable_latch}, 8'h00);
      rdreg(8, 16'h05, 8'h24);
      // Select-pulse reset sequence
      wr(8, 64'h06);
      wr(32, 64'hd8000000);
      wr(8, 64'h75);
      check("suspend pin", {7'h0, suspended_flag}, 8'h01);
      host.pin_reset();
      repeat (4) @(posedge clk_sys);
      check("suspend pin", {7'h0, suspended_flag}, 8'h00);
      // Synchronous reset clears latch and fields
      wr(8, 64'h06);
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rdreg(8, 16'h05, 8'h00);
      end_of_test();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      end_of_test();
   end
endmodule
